//--- iocs_ctrl.sv
/*
 * Pointer-byte register controller: two-wire slave, channel function maps,
 * DAC input/output registers with load control, ADC channel sequencer.
 * Assumes SCL/SDA arrive asynchronously, the ADC result is valid by the
 * SCL falling edge after a start pulse, and an external wire resolves SDA.
 */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - pointer upper nibble 0000 writes control register chosen by lower nibble.
// - after reset every channel uses weak pull-down.
// - bit n of a function register assigns that function to channel n.
// - channel set in several function registers takes the latest write.
// - DAC plus ADC on one channel acts as DAC, ADC still samples.
// - digital input plus output drives as output, input still readable.
// - lock bit set discards writes to function registers.
// - pointer nibble 0001 writes DAC input register chosen by low bits.
// - load-control 00 copies written input register to DAC register at once.
// - load-control 01 keeps data in input register only.
// - load-control 10 copies all input registers, then field returns to 01.
// - pointer nibble 0101 reads back a DAC input register.
// - DAC readback word is 1, DAC number, 12-bit value.
// - sequence written before conversions; tracking begins at first channel.
// - selected channels convert in ascending order.
// - conversion starts on SCL rise of acknowledge before result MSB.
// - after last channel restart if repeat set, else return last result.
// - ADC word is 0, channel number, 12-bit value.
// - new sequence drops pending channels; all bits clear stops sequencing.
// - sequence bit 9 repeat, bit 8 temperature, bits 7:0 channels.
// - lock is bit 7 of general control, reset to zero.
// - sequence at pointer 2; pull-down register resets to all ones.
module iocs_ctrl
    import iocs_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h10
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // two-wire link
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // channel functions and DAC codes
    output iocs_pin_fn_t pin_fn,
    output logic [7:0][11:0] dac_code,
    // converter handshake
    output logic adc_start,
    output logic [3:0] adc_chan,
    input wire logic [11:0] adc_result
);
    logic [1:0] pins_s;
    logic scl_p_q, sda_p_q;
    logic scl_rise, scl_fall, start_c, stop_c, scl_s, sda_s;

    iocs_sync #(.WIDTH(2)) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in({scl_in, sda_in}),
        .sync_out(pins_s)
    );

    // edge and condition detection on the synchronised lines
    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];
    assign scl_rise = scl_s & ~scl_p_q;
    assign scl_fall = ~scl_s & scl_p_q;
    assign start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;

    iocs_state_t st_q, st_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] shift_q, shift_d, ptr_q, ptr_d, msb_q, msb_d;
    logic [1:0] byte_q, byte_d, dac_load_control_q, dac_load_control_d;
    logic rd_q, rd_d, hi_q, hi_d, oe_n_q, oe_n_d;
    logic [15:0] word_q, word_d, res_q, res_d, gpc_q, gpc_d;
    logic [9:0] seq_q, seq_d;
    logic [8:0] pend_q, pend_d;
    logic [7:0][11:0] in_q, in_d, dac_q, dac_d;
    iocs_pin_fn_t fn_q, fn_d;
    logic start_q, start_d, cv_q, cv_d;
    logic [3:0] chan_q, chan_d;
    // helpers shared with checks
    logic commit, conv_ev, load_word;
    logic [15:0] wdata;
    logic [7:0] rx_byte;

    // lowest pending sequence slot, 0xF when none
    function automatic logic [3:0] lowest_set(input logic [8:0] m);
        lowest_set = 4'hF;
        for (int i = 8; i >= 0; i--) begin
            if (m[i]) begin
                lowest_set = i[3:0];
            end
        end
    endfunction

    // last write wins, but DAC/ADC and GPO/GPI pairs may coexist
    function automatic iocs_pin_fn_t apply_fn(input iocs_pin_fn_t f, input logic [3:0] sel,
                                              input logic [7:0] v);
        iocs_pin_fn_t r;
        r = f;
        r.dac = (sel == REG_FN_DAC) ? v : f.dac & ~((sel == REG_FN_ADC) ? 8'h00 : v);
        r.adc = (sel == REG_FN_ADC) ? v : f.adc & ~((sel == REG_FN_DAC) ? 8'h00 : v);
        r.gpo = (sel == REG_FN_GPO) ? v : f.gpo & ~((sel == REG_FN_GPI) ? 8'h00 : v);
        r.gpi = (sel == REG_FN_GPI) ? v : f.gpi & ~((sel == REG_FN_GPO) ? 8'h00 : v);
        r.pd = (sel == REG_FN_PULLDOWN) ? v : f.pd & ~v;
        r.tri_st = (sel == REG_FN_TRISTATE) ? v : f.tri_st & ~v;
        return r;
    endfunction

    // word returned for the pointer in force, built at the MSB load
    function automatic logic [15:0] rd_word(input logic [7:0] p, input logic [15:0] res,
                                            input logic [7:0][11:0] inr);
        if (p[7:4] == PTR_MODE_DAC_RB) begin
            rd_word = {1'b1, p[2:0], inr[p[2:0]]};
        end else begin
            rd_word = res;
        end
    endfunction

    // link byte engine, register file and sequencer
    always_comb begin
        st_d = st_q;
        bit_d = bit_q;
        shift_d = shift_q;
        ptr_d = ptr_q;
        msb_d = msb_q;
        byte_d = byte_q;
        rd_d = rd_q;
        hi_d = hi_q;
        oe_n_d = oe_n_q;
        word_d = word_q;
        res_d = res_q;
        gpc_d = gpc_q;
        seq_d = seq_q;
        pend_d = pend_q;
        dac_load_control_d = dac_load_control_q;
        in_d = in_q;
        dac_d = dac_q;
        fn_d = fn_q;
        start_d = 1'b0;
        cv_d = cv_q;
        chan_d = chan_q;
        commit = 1'b0;
        conv_ev = 1'b0;
        load_word = 1'b0;
        rx_byte = {shift_q[6:0], sda_s};
        wdata = {msb_q, rx_byte};
        unique case (st_q)
            ST_IDLE: begin
                oe_n_d = 1'b1;
            end
            ST_ADDR: begin
                if (scl_rise) begin
                    shift_d = rx_byte;
                    bit_d = bit_q + 4'h1;
                end else if (scl_fall && bit_q == 4'h8) begin
                    bit_d = 4'h0;
                    if (shift_q[7:1] == DEV_ADDR) begin
                        rd_d = shift_q[0];
                        oe_n_d = 1'b0;
                        st_d = ST_SACK;
                    end else begin
                        st_d = ST_IDLE;
                    end
                end
            end
            ST_SACK: begin
                if (scl_rise && rd_q) begin
                    conv_ev = 1'b1;
                end
                if (scl_fall) begin
                    if (rd_q) begin
                        load_word = 1'b1;
                        st_d = ST_RD;
                    end else begin
                        oe_n_d = 1'b1;
                        st_d = ST_WR;
                    end
                end
            end
            ST_WR: begin
                if (scl_rise) begin
                    shift_d = rx_byte;
                    bit_d = bit_q + 4'h1;
                    if (bit_q == 4'h7) begin
                        if (byte_q == 2'h0) begin
                            ptr_d = rx_byte;
                            byte_d = 2'h1;
                        end else if (byte_q == 2'h1) begin
                            msb_d = rx_byte;
                            byte_d = 2'h2;
                        end else begin
                            commit = 1'b1;
                            byte_d = 2'h1;
                        end
                    end
                end else if (scl_fall && bit_q == 4'h8) begin
                    bit_d = 4'h0;
                    oe_n_d = 1'b0;
                    st_d = ST_SACK;
                end
            end
            ST_RD: begin
                if (scl_rise) begin
                    bit_d = bit_q + 4'h1;
                end else if (scl_fall) begin
                    if (bit_q == 4'h8) begin
                        oe_n_d = 1'b1;
                        bit_d = 4'h0;
                        st_d = ST_MACK;
                    end else begin
                        oe_n_d = hi_q ? word_q[4'hF - bit_q] : word_q[4'h7 - bit_q];
                    end
                end
            end
            ST_MACK: begin
                if (scl_rise) begin
                    if (sda_s) begin
                        st_d = ST_IDLE;
                    end else if (!hi_q) begin
                        conv_ev = 1'b1;
                    end
                end else if (scl_fall) begin
                    st_d = ST_RD;
                    if (hi_q) begin
                        hi_d = 1'b0;
                        oe_n_d = word_q[7];
                    end else begin
                        load_word = 1'b1;
                    end
                end
            end
        endcase
        // conversion start: lowest pending slot first, reload on repeat
        if (conv_ev && ptr_q[7:4] == PTR_MODE_ADC_RD) begin
            cv_d = 1'b0;
            if (pend_q != 9'h000) begin
                chan_d = lowest_set(pend_q);
                pend_d = pend_q & ~(9'h001 << lowest_set(pend_q));
                if (pend_d == 9'h000 && seq_q[SEQ_REPEAT_BIT]) begin
                    pend_d = seq_q[8:0];
                end
                start_d = 1'b1;
                cv_d = 1'b1;
            end
        end
        // MSB load: fresh result if converted, else the last one held
        if (load_word) begin
            if (cv_q) begin
                res_d = {1'b0, chan_q[2:0], adc_result};
                cv_d = 1'b0;
            end
            word_d = rd_word(ptr_q, cv_q ? res_d : res_q, in_q);
            hi_d = 1'b1;
            bit_d = 4'h0;
            oe_n_d = word_d[15];
        end
        // register writes on each completed data word
        if (commit && ptr_q[7:4] == PTR_MODE_CTRL) begin
            unique case (ptr_q[3:0])
                REG_ADC_SEQUENCE: begin
                    seq_d = wdata[9:0];
                    pend_d = wdata[8:0];
                end
                REG_GP_CONTROL: begin
                    gpc_d = wdata & GPC_WRITABLE;
                end
                REG_FN_ADC, REG_FN_DAC, REG_FN_PULLDOWN, REG_FN_GPO, REG_FN_GPI, REG_FN_TRISTATE: begin
                    if (!gpc_q[GPC_LOCK_BIT]) begin
                        fn_d = apply_fn(fn_q, ptr_q[3:0], wdata[7:0]);
                    end
                end
                REG_DAC_LOAD_CONTROL: begin
                    if (wdata[1:0] == LOAD_ALL) begin
                        dac_d = in_q;
                        dac_load_control_d = LOAD_HOLD;
                    end else begin
                        dac_load_control_d = wdata[1:0];
                    end
                end
                default: begin
                end
            endcase
        end else if (commit && ptr_q[7:4] == PTR_MODE_DAC_WR) begin
            for (int i = 0; i < 8; i++) begin
                if (gpc_q[GPC_WRITE_ALL_BIT] ? fn_q.dac[i] : (ptr_q[2:0] == i[2:0])) begin
                    in_d[i] = wdata[11:0];
                    if (dac_load_control_q == LOAD_DIRECT) begin
                        dac_d[i] = wdata[11:0];
                    end
                end
            end
        end
        // start and stop override the byte engine anywhere
        if (start_c) begin
            st_d = ST_ADDR;
            bit_d = 4'h0;
            byte_d = 2'h0;
            oe_n_d = 1'b1;
        end else if (stop_c) begin
            st_d = ST_IDLE;
            oe_n_d = 1'b1;
        end
    end

    // state registers; pull-down is the power-up function
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            st_q <= ST_IDLE;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            msb_q <= 8'h00;
            byte_q <= 2'h0;
            rd_q <= 1'b0;
            hi_q <= 1'b0;
            oe_n_q <= 1'b1;
            word_q <= 16'h0000;
            res_q <= 16'h0000;
            gpc_q <= 16'h0000;
            seq_q <= SEQ_RESET;
            pend_q <= 9'h000;
            dac_load_control_q <= LOAD_DIRECT;
            in_q <= '0;
            dac_q <= '0;
            fn_q <= '{pd: PULLDOWN_RESET, default: 8'h00};
            start_q <= 1'b0;
            cv_q <= 1'b0;
            chan_q <= 4'h0;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
            st_q <= st_d;
            bit_q <= bit_d;
            shift_q <= shift_d;
            ptr_q <= ptr_d;
            msb_q <= msb_d;
            byte_q <= byte_d;
            rd_q <= rd_d;
            hi_q <= hi_d;
            oe_n_q <= oe_n_d;
            word_q <= word_d;
            res_q <= res_d;
            gpc_q <= gpc_d;
            seq_q <= seq_d;
            pend_q <= pend_d;
            dac_load_control_q <= dac_load_control_d;
            in_q <= in_d;
            dac_q <= dac_d;
            fn_q <= fn_d;
            start_q <= start_d;
            cv_q <= cv_d;
            chan_q <= chan_d;
        end
    end

    // outputs straight from flops; open-drain so data output is a constant low, gated by sda_oe_n
    assign sda_out = 1'b0;
    assign sda_oe_n = oe_n_q;
    assign pin_fn = fn_q;
    assign dac_code = dac_q;
    assign adc_start = start_q;
    assign adc_chan = chan_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_pd_after_reset: assert property ($fell(rst) |-> fn_q.pd == PULLDOWN_RESET && fn_q.dac == 8'h00)
        else $error("pull-down not default after reset");
    chk_seq_write_lands: assert property (commit && ptr_q == {PTR_MODE_CTRL, REG_ADC_SEQUENCE}
        |=> seq_q == $past(wdata[9:0]) && pend_q == $past(wdata[8:0]))
        else $error("sequence write not stored");
    chk_lock_blocks_fn: assert property (commit && gpc_q[GPC_LOCK_BIT] && ptr_q[7:4] == PTR_MODE_CTRL
        |=> $stable(fn_q))
        else $error("function changed while locked");
    chk_fn_last_wins: assert property (commit && !gpc_q[GPC_LOCK_BIT] && ptr_q == {PTR_MODE_CTRL, REG_FN_GPO}
        |=> fn_q.gpo == $past(wdata[7:0]) && (fn_q.dac & fn_q.gpo) == 8'h00)
        else $error("latest function write not applied");
    chk_dac_load_control_direct: assert property (commit && ptr_q[7:4] == PTR_MODE_DAC_WR && dac_load_control_q == LOAD_DIRECT
        && !gpc_q[GPC_WRITE_ALL_BIT] |=> dac_q[$past(ptr_q[2:0])] == $past(wdata[11:0]))
        else $error("direct load did not update DAC");
    chk_dac_load_control_hold: assert property (commit && ptr_q[7:4] == PTR_MODE_DAC_WR && dac_load_control_q == LOAD_HOLD
        |=> $stable(dac_q))
        else $error("held load changed DAC");
    chk_dac_load_control_revert: assert property (commit && ptr_q == {PTR_MODE_CTRL, REG_DAC_LOAD_CONTROL}
        && wdata[1:0] == LOAD_ALL |=> dac_load_control_q == LOAD_HOLD && dac_q == $past(in_q))
        else $error("load-all did not copy and revert");
    chk_rb_word_kind: assert property (load_word && ptr_q[7:4] == PTR_MODE_DAC_RB
        |=> word_q[WORD_KIND_BIT] && word_q[14:12] == ptr_q[2:0])
        else $error("DAC readback word malformed");
    chk_adc_word_kind: assert property (load_word && ptr_q[7:4] == PTR_MODE_ADC_RD
        |=> !word_q[WORD_KIND_BIT])
        else $error("ADC word kind bit set");
    chk_start_on_ack: assert property (start_q |-> $past(conv_ev) && $past(st_q) inside {ST_SACK, ST_MACK})
        else $error("conversion started off the acknowledge edge");
    chk_ascending: assert property (start_q && chan_q != 4'h0 |-> ($past(pend_q) & ((9'h001 << chan_q) - 9'h001))
        == 9'h000)
        else $error("lower channel skipped");

endmodule
`default_nettype wire

//--- iocs_i2c_master.sv
/*
 * Two-wire bus controller model driving the link of the channel controller.
 * Assumes an open-drain data wire with a pull-up resolved by the bench;
 * SCL idles high between frames and runs at an 80 ns period inside them.
 */
`timescale 1ns/1ps
`default_nettype none
module iocs_i2c_master (
    // clock used only to align frame starts
    input wire logic ref_clk,
    // link pins, sda_m high means released
    output logic scl,
    output logic sda_m,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end

    // start: data falls while clock high; steps after the 1 ns offset are multiples of 8 ns
    task automatic start();
        @(posedge ref_clk);
        #1;
        #40 sda_m = 1'b0;
        #40 scl = 1'b0;
    endtask

    // stop: data rises while clock high, then the bus rests
    task automatic stop();
        #16 sda_m = 1'b0;
        #24 scl = 1'b1;
        #40 sda_m = 1'b1;
        #80;
    endtask

    // one bit: data set in the low phase, sampled mid high phase
    task automatic bit_io(input logic b, output logic r);
        #16 sda_m = b;
        #24 scl = 1'b1;
        #24 r = sda;
        #16 scl = 1'b0;
    endtask

    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, ack);
    endtask

    // nack high ends a read so the device goes idle
    task automatic rd_byte(input logic nack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, b[i]);
        end
        bit_io(nack, r);
    endtask
endmodule
`default_nettype wire

//--- iocs_pkg.sv
/*
 * Shared constants and types for the I/O channel configuration, DAC load
 * and ADC sequencing controller.
 * Assumes an I2C-style two-wire link sampled by a single 125 MHz clock.
 */
package iocs_pkg;

    // pointer byte mode field (upper nibble)
    localparam logic [3:0] PTR_MODE_CTRL = 4'h0;
    localparam logic [3:0] PTR_MODE_DAC_WR = 4'h1;
    localparam logic [3:0] PTR_MODE_ADC_RD = 4'h4;
    localparam logic [3:0] PTR_MODE_DAC_RB = 4'h5;

    // control register offsets (lower pointer nibble)
    localparam logic [3:0] REG_NO_OPERATION_POINTER = 4'h0;
    localparam logic [3:0] REG_ADC_SEQUENCE = 4'h2;
    localparam logic [3:0] REG_GP_CONTROL = 4'h3;
    localparam logic [3:0] REG_FN_ADC = 4'h4;
    localparam logic [3:0] REG_FN_DAC = 4'h5;
    localparam logic [3:0] REG_FN_PULLDOWN = 4'h6;
    localparam logic [3:0] REG_DAC_LOAD_CONTROL = 4'h7;
    localparam logic [3:0] REG_FN_GPO = 4'h8;
    localparam logic [3:0] REG_FN_GPI = 4'hA;
    localparam logic [3:0] REG_FN_TRISTATE = 4'hD;

    // field positions
    localparam int SEQ_REPEAT_BIT = 9;
    localparam int SEQ_TEMP_BIT = 8;
    localparam int GPC_LOCK_BIT = 7;
    localparam int GPC_WRITE_ALL_BIT = 6;
    localparam int WORD_KIND_BIT = 15;

    // reset values and masks
    localparam logic [15:0] GPC_WRITABLE = 16'h03F0;
    localparam logic [7:0] PULLDOWN_RESET = 8'hFF;
    localparam logic [9:0] SEQ_RESET = 10'h000;

    // dac_load_control field codes
    localparam logic [1:0] LOAD_DIRECT = 2'h0;
    localparam logic [1:0] LOAD_HOLD = 2'h1;
    localparam logic [1:0] LOAD_ALL = 2'h2;

    // temperature indicator slot in the sequence
    localparam logic [3:0] TEMP_CHANNEL = 4'h8;

    // per-channel function maps
    typedef struct packed {
        logic [7:0] dac;
        logic [7:0] adc;
        logic [7:0] gpo;
        logic [7:0] gpi;
        logic [7:0] pd;
        logic [7:0] tri_st;
    } iocs_pin_fn_t;

    typedef enum {
        ST_IDLE, ST_ADDR, ST_SACK, ST_WR, ST_RD, ST_MACK
    } iocs_state_t;

endpackage

//--- iocs_sync.sv
/*
 * Two-flop synchroniser for the link pins.
 * Assumes inputs are asynchronous to ref_clk; output lags by two edges.
 */
`timescale 1ns/1ps
`default_nettype none
module iocs_sync #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // pins in, synchronised out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second; idle link lines sit high
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_q <= '1;
            sync_out <= '1;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

//--- tb_iocs_ctrl.sv
/*
 * Self-checking bench for the channel controller: function maps, lock,
 * DAC load modes, readback words and the ADC sequencer.
 * Assumes the bus controller model and a converter stand-in inside.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_iocs_ctrl;
    import iocs_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic scl, sda_m, sda_out, sda_oe_n, adc_start, ack;
    wire sda_line;
    iocs_pin_fn_t pin_fn;
    logic [7:0][11:0] dac_code, inr, dacx;
    logic [3:0] adc_chan;
    logic [11:0] adc_result = 12'h000;
    logic [15:0] exp_q[$];
    int err_count = 0, samples_checked = 0, seed = 16, cyc = 0, starts = 0, s0;

    // pull-up wire: either party may pull low
    assign sda_line = sda_m & (sda_oe_n | sda_out);

    iocs_ctrl #(.DEV_ADDR(7'h10)) iocs_ctrl_i (.ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .pin_fn(pin_fn), .dac_code(dac_code),
        .adc_start(adc_start), .adc_chan(adc_chan), .adc_result(adc_result));
    iocs_i2c_master iocs_i2c_master_i (.ref_clk(ref_clk), .scl(scl), .sda_m(sda_m), .sda(sda_line));

    initial forever #4 ref_clk = ~ref_clk;

    // converter stand-in value per channel, arbitrary but distinct
    function automatic logic [11:0] conv(input logic [3:0] ch);
        return 12'h5A0 ^ {ch, ch, ch};
    endfunction

    // expected result word; temperature slot carries address 0
    function automatic logic [15:0] aw(input logic [3:0] ch);
        return {1'b0, (ch[3] ? 3'b000 : ch[2:0]), conv(ch)};
    endfunction

    // converter answers one cycle after each start, well before the SCL fall
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (adc_start === 1'b1) begin
            starts <= starts + 1;
            adc_result <= #1 conv(adc_chan);
        end
        if (cyc == 60000) begin
            err_count++;
            wrap_up();
        end
    end

    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // write frame: pointer, then one 16-bit word when has_d is set
    task automatic wr(input logic [7:0] p, input logic [15:0] d, input bit has_d);
        iocs_i2c_master_i.start();
        iocs_i2c_master_i.wr_byte({7'h10, 1'b0}, ack);
        chk(ack, 1'b0);
        iocs_i2c_master_i.wr_byte(p, ack);
        chk(ack, 1'b0);
        if (has_d) begin
            iocs_i2c_master_i.wr_byte(d[15:8], ack);
            chk(ack, 1'b0);
            iocs_i2c_master_i.wr_byte(d[7:0], ack);
            chk(ack, 1'b0);
        end
        iocs_i2c_master_i.stop();
    endtask

    // read as many words as exp_q holds, nack on the last byte
    task automatic rd_words();
        logic [7:0] hi, lo;
        iocs_i2c_master_i.start();
        iocs_i2c_master_i.wr_byte({7'h10, 1'b1}, ack);
        chk(ack, 1'b0);
        foreach (exp_q[i]) begin
            iocs_i2c_master_i.rd_byte(1'b0, hi);
            iocs_i2c_master_i.rd_byte(i == exp_q.size() - 1, lo);
            chk({hi, lo}, exp_q[i]);
        end
        iocs_i2c_master_i.stop();
        exp_q.delete();
    endtask

    task automatic wrap_up();
        $display("errors %0d, checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge ref_clk);
        #1 rst = 1'b0;
        repeat (6) @(posedge ref_clk);
        chk(pin_fn, 48'h0000_0000_FF00);
        chk(dac_code, 96'h0);
        // functions change only on function register writes while unlocked
        wr(8'h05, 16'h0082, 1);
        chk(pin_fn.dac, 8'h82);
        chk(pin_fn.pd, 8'h7D);
        wr(8'h06, 16'h0002, 1);
        chk({pin_fn.dac, pin_fn.pd}, 16'h8002);
        wr(8'h04, 16'h0081, 1);
        chk({pin_fn.dac, pin_fn.adc}, 16'h8081);
        wr(8'h08, 16'h0010, 1);
        wr(8'h0A, 16'h0010, 1);
        chk({pin_fn.gpo, pin_fn.gpi}, 16'h1010);
        wr(8'h0D, 16'h0020, 1);
        chk(pin_fn.tri_st, 8'h20);
        wr(8'h03, 16'h0080, 1);
        wr(8'h05, 16'h00FF, 1);
        chk(pin_fn.dac, 8'h80);
        wr(8'h03, 16'h0000, 1);
        wr(8'h0E, 16'hFFFF, 1);
        wr(8'h30, 16'hFFFF, 1);
        // a frame for another address is not answered
        iocs_i2c_master_i.start();
        iocs_i2c_master_i.wr_byte({7'h11, 1'b0}, ack);
        chk(ack, 1'b1);
        iocs_i2c_master_i.stop();
        chk(pin_fn, 48'h8081_1010_0220);
        chk(dac_code, 96'h0);
        // direct load: each write lands in its DAC register
        for (int i = 0; i < 8; i++) begin
            inr[i] = 12'($random(seed));
            wr({5'b00010, i[2:0]}, {1'b0, i[2:0], inr[i]}, 1);
            chk(dac_code[i], inr[i]);
        end
        dacx = inr;
        wr(8'h07, 16'h0001, 1);
        for (int i = 0; i < 8; i++) begin
            inr[i] = 12'($random(seed));
            wr({5'b00010, i[2:0]}, {1'b0, i[2:0], inr[i]}, 1);
            chk(dac_code, dacx);
        end
        // readback with no sequence running
        for (int i = 0; i < 8; i++) begin
            wr({5'b01010, i[2:0]}, 16'h0000, 0);
            exp_q.push_back({1'b1, i[2:0], inr[i]});
            rd_words();
        end
        wr(8'h07, 16'h0002, 1);
        chk(dac_code, inr);
        // field has returned to hold, so a new write stays pending
        wr(8'h13, {4'h3, ~inr[3]}, 1);
        chk(dac_code, inr);
        // write-all in direct mode: only channels marked as DAC take the word
        wr(8'h07, 16'h0000, 1);
        wr(8'h03, 16'h0040, 1);
        wr(8'h10, 16'h0ABC, 1);
        chk(dac_code[7], 12'hABC);
        chk(dac_code[0], inr[0]);
        wr(8'h03, 16'h0000, 1);
        // repeat with channels 7 and 0, read as one block
        wr(8'h02, 16'h0281, 1);
        wr(8'h40, 16'h0000, 0);
        s0 = starts;
        exp_q = '{aw(4'h0), aw(4'h7), aw(4'h0), aw(4'h7), aw(4'h0)};
        rd_words();
        chk(starts - s0, 5);
        // new sequence drops pending, temperature slot, then last result held
        wr(8'h02, 16'h0104, 1);
        wr(8'h40, 16'h0000, 0);
        exp_q = '{aw(4'h2), aw(4'h8), aw(4'h8)};
        rd_words();
        wr(8'h02, 16'h0000, 1);
        wr(8'h40, 16'h0000, 0);
        exp_q = '{aw(4'h8)};
        rd_words();
        wrap_up();
    end
endmodule
`default_nettype wire
